// >>> pkg/sac_pkg.sv
// shared constants and types for the set-associative cache with code-modification detection
package sac_pkg;
  localparam int ADDR_W      = 32;
  localparam int NUM_SETS    = 16;
  localparam int NUM_WAYS    = 4;
  localparam int LINE_BYTES  = 16;
  localparam int OFF_W       = $clog2(LINE_BYTES);
  localparam int IDX_W       = $clog2(NUM_SETS);
  localparam int TAG_W       = ADDR_W - IDX_W - OFF_W;
  localparam int WAY_W       = $clog2(NUM_WAYS);
  localparam int LINE_W      = LINE_BYTES * 8;
  localparam int PRED_W      = 8;
  localparam int FLIGHT_N    = 4;
  localparam int QWORD_SHIFT = 3;
  localparam logic [WAY_W-1:0] AGE_RESET = 2'h0;

  typedef enum logic [4:0] {
    ST_INVALID   = 5'h01,
    ST_SHARED    = 5'h02,
    ST_EXCLUSIVE = 5'h04,
    ST_OWNED     = 5'h08,
    ST_MODIFIED  = 5'h10
  } sac_coh_type;

  typedef enum logic [2:0] {
    FS_IDLE  = 3'h1,
    FS_FLUSH = 3'h2,
    FS_RUN   = 3'h4
  } sac_fetch_type;
endpackage

// >>> hw/sac_way_match.sv
// one way's tag compare for the indexed set
`timescale 1ns/1ps
`default_nettype none
module sac_way_match
  import sac_pkg::*;
(
  input  wire logic             lineValid,
  input  wire logic [TAG_W-1:0] storedTag,
  input  wire logic [TAG_W-1:0] addrTag,
  output logic                  match
);
  assign match = lineValid && (storedTag == addrTag);
endmodule
`default_nettype wire

// >>> hw/sac_flight_check.sv
// compares a store's physical address against one in-flight instruction slot
`timescale 1ns/1ps
`default_nettype none
module sac_flight_check
  import sac_pkg::*;
(
  input  wire logic              slotValid,
  input  wire logic [ADDR_W-1:0] slotAddr,
  input  wire logic              storeValid,
  input  wire logic [ADDR_W-1:0] storeAddr,
  output logic                   hit
);
  // quadword granularity: fetch may reread the quadword, so any store in it flushes
  assign hit = slotValid && storeValid &&
               (slotAddr[ADDR_W-1:QWORD_SHIFT] == storeAddr[ADDR_W-1:QWORD_SHIFT]);
endmodule
`default_nettype wire

// >>> hw/sac_cache.sv
// set-associative cache lookup with instruction-line invalidation on stores
`timescale 1ns/1ps
`default_nettype none
module sac_cache
  import sac_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_b,
  // data-side access (load or store), one per cycle
  input  wire logic                accValid,
  input  wire logic                accWrite,
  input  wire logic [ADDR_W-1:0]   accAddr,
  input  wire logic [63:0]         accWdata,
  input  wire logic [7:0]          accBe,
  output logic                     accHit,
  output logic                     accMiss,
  output logic [63:0]              accRdata,
  output logic [WAY_W-1:0]         accWay,
  // instruction fetch lookup
  input  wire logic                fetValid,
  input  wire logic [ADDR_W-1:0]   fetAddr,
  output logic                     fetHit,
  output logic [63:0]              fetData,
  output logic [PRED_W-1:0]        fetPred,
  // fill from the hierarchy into the data or instruction side
  input  wire logic                fillValid,
  input  wire logic                fillInstr,
  input  wire logic [ADDR_W-1:0]   fillAddr,
  input  wire logic [LINE_W-1:0]   fillData,
  input  wire logic [PRED_W-1:0]   fillPred,
  input  wire logic                fillExcl,
  output logic [WAY_W-1:0]         fillWayOut,
  // in-flight instruction physical addresses from decode and execute
  input  wire logic [FLIGHT_N-1:0] flightValid,
  input  wire logic [FLIGHT_N*ADDR_W-1:0] flightAddr,
  input  wire logic                serializeExec,
  output logic                     pipeFlush,
  output logic                     fetchRestart,
  output logic                     icInvalidate
);
  // storage
  logic [LINE_W-1:0] dData_q [NUM_SETS][NUM_WAYS];
  logic [TAG_W-1:0]  dTag_q  [NUM_SETS][NUM_WAYS];
  sac_coh_type       dCoh_q  [NUM_SETS][NUM_WAYS];
  logic [LINE_W-1:0] iData_q [NUM_SETS][NUM_WAYS];
  logic [TAG_W-1:0]  iTag_q  [NUM_SETS][NUM_WAYS];
  logic              iVal_q  [NUM_SETS][NUM_WAYS];
  logic [PRED_W-1:0] iPred_q [NUM_SETS][NUM_WAYS];
  logic [WAY_W-1:0]  dAge_q  [NUM_SETS][NUM_WAYS];
  logic [WAY_W-1:0]  iAge_q  [NUM_SETS][NUM_WAYS];
  sac_fetch_type     fState_q;

  // address fields
  logic [IDX_W-1:0] aIdx;
  logic [TAG_W-1:0] aTag;
  logic [OFF_W-1:0] aOff;
  logic [IDX_W-1:0] fIdx;
  logic [TAG_W-1:0] fTag;
  logic [OFF_W-1:0] fOff;
  logic [IDX_W-1:0] lIdx;
  logic [TAG_W-1:0] lTag;
  assign aIdx = accAddr[OFF_W +: IDX_W];
  assign aTag = accAddr[ADDR_W-1 -: TAG_W];
  assign aOff = accAddr[OFF_W-1:0];
  assign fIdx = fetAddr[OFF_W +: IDX_W];
  assign fTag = fetAddr[ADDR_W-1 -: TAG_W];
  assign fOff = fetAddr[OFF_W-1:0];
  assign lIdx = fillAddr[OFF_W +: IDX_W];
  assign lTag = fillAddr[ADDR_W-1 -: TAG_W];

  // per-way compare for data, fetch and store-snoop of instruction lines
  logic [NUM_WAYS-1:0] dMatch;
  logic [NUM_WAYS-1:0] fMatch;
  logic [NUM_WAYS-1:0] sMatch;
  genvar gw;
  generate
    for (gw = 0; gw < NUM_WAYS; gw++) begin : g_way
      sac_way_match u_d (
        .lineValid (dCoh_q[aIdx][gw] != ST_INVALID),
        .storedTag (dTag_q[aIdx][gw]),
        .addrTag   (aTag),
        .match     (dMatch[gw])
      );
      sac_way_match u_f (
        .lineValid (iVal_q[fIdx][gw]),
        .storedTag (iTag_q[fIdx][gw]),
        .addrTag   (fTag),
        .match     (fMatch[gw])
      );
      sac_way_match u_s (
        .lineValid (iVal_q[aIdx][gw]),
        .storedTag (iTag_q[aIdx][gw]),
        .addrTag   (aTag),
        .match     (sMatch[gw])
      );
    end
  endgenerate

  // n:1 way mux
  logic [WAY_W-1:0]  dWay;
  logic [WAY_W-1:0]  fWay;
  logic [LINE_W-1:0] dLine;
  logic [LINE_W-1:0] fLine;
  always_comb begin
    dWay = '0;
    fWay = '0;
    for (int w = 0; w < NUM_WAYS; w++) begin
      if (dMatch[w]) dWay = WAY_W'(w);
      if (fMatch[w]) fWay = WAY_W'(w);
    end
    dLine = dData_q[aIdx][dWay];
    fLine = iData_q[fIdx][fWay];
  end

  // victim: oldest way, invalid ways first
  function automatic logic [WAY_W-1:0] pickVictim(input logic [NUM_WAYS-1:0] valid,
                                                   input logic [NUM_WAYS*WAY_W-1:0] ages);
    logic [WAY_W-1:0] v;
    logic             found;
    v = '0;
    found = 1'b0;
    for (int w = 0; w < NUM_WAYS; w++) begin
      if (!found && !valid[w]) begin
        v = WAY_W'(w);
        found = 1'b1;
      end
    end
    for (int w = 0; w < NUM_WAYS; w++) begin
      if (!found && ages[w*WAY_W +: WAY_W] == WAY_W'(NUM_WAYS-1)) begin
        v = WAY_W'(w);
        found = 1'b1;
      end
    end
    return v;
  endfunction

  logic [NUM_WAYS-1:0]       lValid;
  logic [NUM_WAYS*WAY_W-1:0] lAges;
  logic [WAY_W-1:0]          fillWay;
  always_comb begin
    for (int w = 0; w < NUM_WAYS; w++) begin
      lValid[w] = fillInstr ? iVal_q[lIdx][w] : (dCoh_q[lIdx][w] != ST_INVALID);
      lAges[w*WAY_W +: WAY_W] = fillInstr ? iAge_q[lIdx][w] : dAge_q[lIdx][w];
    end
    fillWay = pickVictim(lValid, lAges);
  end

  logic storeHitI;
  logic dAccHit;
  logic storeReq;
  assign dAccHit   = accValid && (|dMatch);
  assign storeReq  = accValid && accWrite;
  assign storeHitI = storeReq && (|sMatch);

  // data side storage: fills, stores at the offset, coherence
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int s = 0; s < NUM_SETS; s++) begin
        for (int w = 0; w < NUM_WAYS; w++) begin
          dCoh_q[s][w]  <= ST_INVALID;
          dTag_q[s][w]  <= '0;
          dData_q[s][w] <= '0;
        end
      end
    end else begin
      if (fillValid && !fillInstr) begin
        dData_q[lIdx][fillWay] <= fillData;
        dTag_q[lIdx][fillWay]  <= lTag;
        dCoh_q[lIdx][fillWay]  <= fillExcl ? ST_EXCLUSIVE : ST_SHARED;
      end
      if (dAccHit && accWrite) begin
        for (int b = 0; b < 8; b++) begin
          // bytes past the line end are dropped; caller splits crossing stores
          if (accBe[b] && (int'(aOff) + b) < LINE_BYTES)
            dData_q[aIdx][dWay][(int'(aOff) + b)*8 +: 8] <= accWdata[b*8 +: 8];
        end
        // a store to code marks the line owned, any other store marks it modified
        dCoh_q[aIdx][dWay] <= storeHitI ? ST_OWNED : ST_MODIFIED;
      end
    end
  end

  // instruction side: fills and invalidation by stores
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int s = 0; s < NUM_SETS; s++) begin
        for (int w = 0; w < NUM_WAYS; w++) begin
          iVal_q[s][w]  <= 1'b0;
          iTag_q[s][w]  <= '0;
          iData_q[s][w] <= '0;
          iPred_q[s][w] <= '0;
        end
      end
    end else begin
      if (fillValid && fillInstr) begin
        iData_q[lIdx][fillWay] <= fillData;
        iTag_q[lIdx][fillWay]  <= lTag;
        iPred_q[lIdx][fillWay] <= fillPred;
        iVal_q[lIdx][fillWay]  <= 1'b1;
      end
      // invalidate after the fill; a same-cycle store matches only lines held before the fill
      for (int w = 0; w < NUM_WAYS; w++) begin
        if (storeHitI && sMatch[w]) iVal_q[aIdx][w] <= 1'b0;
      end
      if (serializeExec) begin
        // discard anything fetched speculatively before the serialize
        for (int s = 0; s < NUM_SETS; s++) begin
          for (int w = 0; w < NUM_WAYS; w++) iVal_q[s][w] <= 1'b0;
        end
      end
    end
  end

  // age counters: touched way to zero, younger ways age by one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int s = 0; s < NUM_SETS; s++) begin
        for (int w = 0; w < NUM_WAYS; w++) begin
          dAge_q[s][w] <= WAY_W'(w);
          iAge_q[s][w] <= WAY_W'(w);
        end
      end
    end else begin
      if (fillValid && !fillInstr) begin
        for (int w = 0; w < NUM_WAYS; w++) begin
          if (WAY_W'(w) == fillWay) dAge_q[lIdx][w] <= AGE_RESET;
          else if (dAge_q[lIdx][w] < dAge_q[lIdx][fillWay])
            dAge_q[lIdx][w] <= dAge_q[lIdx][w] + 1'b1;
        end
      end else if (dAccHit) begin
        for (int w = 0; w < NUM_WAYS; w++) begin
          if (WAY_W'(w) == dWay) dAge_q[aIdx][w] <= AGE_RESET;
          else if (dAge_q[aIdx][w] < dAge_q[aIdx][dWay])
            dAge_q[aIdx][w] <= dAge_q[aIdx][w] + 1'b1;
        end
      end
      if (fillValid && fillInstr) begin
        for (int w = 0; w < NUM_WAYS; w++) begin
          if (WAY_W'(w) == fillWay) iAge_q[lIdx][w] <= AGE_RESET;
          else if (iAge_q[lIdx][w] < iAge_q[lIdx][fillWay])
            iAge_q[lIdx][w] <= iAge_q[lIdx][w] + 1'b1;
        end
      end else if (fetValid && (|fMatch)) begin
        for (int w = 0; w < NUM_WAYS; w++) begin
          if (WAY_W'(w) == fWay) iAge_q[fIdx][w] <= AGE_RESET;
          else if (iAge_q[fIdx][w] < iAge_q[fIdx][fWay])
            iAge_q[fIdx][w] <= iAge_q[fIdx][w] + 1'b1;
        end
      end
    end
  end

  // registered answers, one cycle after the request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      accHit     <= 1'b0;
      accMiss    <= 1'b0;
      accRdata   <= '0;
      accWay     <= '0;
      fetHit     <= 1'b0;
      fetData    <= '0;
      fetPred    <= '0;
      fillWayOut <= '0;
    end else begin
      accHit     <= dAccHit;
      accMiss    <= accValid && !(|dMatch);
      accWay     <= dWay;
      accRdata   <= 64'(dLine >> {aOff, 3'h0});
      // an instruction line being invalidated this cycle must not be served
      fetHit     <= fetValid && (|fMatch) && !serializeExec &&
                    !(storeHitI && fIdx == aIdx && (|(fMatch & sMatch)));
      fetData    <= 64'(fLine >> {fOff, 3'h0});
      fetPred    <= iPred_q[fIdx][fWay];
      fillWayOut <= fillWay;
    end
  end

  // store against in-flight instructions
  logic [FLIGHT_N-1:0] fHit;
  genvar gf;
  generate
    for (gf = 0; gf < FLIGHT_N; gf++) begin : g_flight
      sac_flight_check u_chk (
        .slotValid  (flightValid[gf]),
        .slotAddr   (flightAddr[gf*ADDR_W +: ADDR_W]),
        .storeValid (storeReq),
        .storeAddr  (accAddr),
        .hit        (fHit[gf])
      );
    end
  endgenerate

  // fetch control: flush one cycle, then restart pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fState_q <= FS_IDLE;
    end else begin
      case (fState_q)
        FS_IDLE:  if ((|fHit) || serializeExec) fState_q <= FS_FLUSH;
        FS_FLUSH: fState_q <= FS_RUN;
        FS_RUN:   fState_q <= ((|fHit) || serializeExec) ? FS_FLUSH : FS_IDLE;
        default:  fState_q <= FS_IDLE;
      endcase
    end
  end
  assign pipeFlush    = (fState_q == FS_FLUSH);
  assign fetchRestart = (fState_q == FS_RUN);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) icInvalidate <= 1'b0;
    else        icInvalidate <= storeHitI;
  end

  p_store_flush: assert property (@(posedge clk) disable iff (!rst_b)
    (|fHit) && fState_q != FS_FLUSH |=> pipeFlush ##1 fetchRestart)
    else $error("in-flight store hit did not flush and restart");
  a_store_flush: assert property (@(posedge clk) disable iff (!rst_b)
    (|fHit) |=> pipeFlush || fetchRestart)
    else $error("flush missing after in-flight hit");
  p_ic_inval: assert property (@(posedge clk) disable iff (!rst_b)
    storeHitI && !fillValid |=> icInvalidate && (!iVal_q[$past(aIdx)][0] || !$past(sMatch[0])))
    else $error("instruction line not invalidated by store");
  a_ic_inval: assert property (@(posedge clk) disable iff (!rst_b)
    storeHitI |=> icInvalidate)
    else $error("store hit on code not reported");
  a_hit_miss: assert property (@(posedge clk) disable iff (!rst_b)
    accValid |=> (accHit ^ accMiss))
    else $error("hit and miss not exclusive");
  a_no_req: assert property (@(posedge clk) disable iff (!rst_b)
    !accValid |=> !accHit && !accMiss)
    else $error("answer without request");
  a_serialize: assert property (@(posedge clk) disable iff (!rst_b)
    serializeExec |=> !fetHit ##0 (pipeFlush || fetchRestart))
    else $error("serialize did not discard fetched bytes");
  a_onehot_hit: assert property (@(posedge clk) disable iff (!rst_b)
    $onehot0(dMatch))
    else $error("tag hit in more than one way");
  a_victim: assert property (@(posedge clk) disable iff (!rst_b)
    fillValid && !fillInstr |=> dAge_q[$past(lIdx)][$past(fillWay)] == AGE_RESET)
    else $error("filled way not made youngest");
  a_restart_after: assert property (@(posedge clk) disable iff (!rst_b)
    fetchRestart |-> $past(pipeFlush))
    else $error("restart without preceding flush");
endmodule
`default_nettype wire

// >>> sim/sac_pipe_model.sv
// pipeline model: in-flight instruction slots and serializing instruction
`timescale 1ns/1ps
`default_nettype none
module sac_pipe_model
  import sac_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic                        pipeFlush,
  input  wire logic                        slotLoad,
  input  wire logic [$clog2(FLIGHT_N)-1:0] slotIdx,
  input  wire logic [ADDR_W-1:0]           slotAddr,
  input  wire logic                        serReq,
  output logic      [FLIGHT_N-1:0]         flightValid,
  output logic      [FLIGHT_N*ADDR_W-1:0]  flightAddr,
  output logic                             serializeExec
);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flightValid <= '0;
      flightAddr  <= '0;
    end else if (pipeFlush) begin
      // flushed slots are dead; scramble so a stale address cannot match
      flightValid <= '0;
      flightAddr  <= ~flightAddr;
    end else if (slotLoad) begin
      flightValid[slotIdx]                 <= 1'b1;
      flightAddr[slotIdx*ADDR_W +: ADDR_W] <= slotAddr;
    end
  end

  // serializeExec is serReq registered one cycle later, with no other condition
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      serializeExec <= 1'b0;
    end else begin
      serializeExec <= serReq;
    end
  end
endmodule
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench for the cache lookup and code-modification block
`timescale 1ns/1ps
`default_nettype none
module tb
  import sac_pkg::*;
;
  logic                        clk, rst_b, accValid, accWrite, fetValid, fillValid, fillInstr;
  logic                        fillExcl, serializeExec, pipeFlush, fetchRestart, icInvalidate;
  logic                        accHit, accMiss, fetHit, slotLoad, serReq;
  logic [ADDR_W-1:0]           accAddr, fetAddr, fillAddr, slotAddr;
  logic [63:0]                 accWdata, accRdata, fetData, d;
  logic [7:0]                  accBe;
  logic [WAY_W-1:0]            accWay, fillWayOut;
  logic [PRED_W-1:0]           fetPred, fillPred;
  logic [LINE_W-1:0]           fillData, ln;
  logic [FLIGHT_N-1:0]         flightValid;
  logic [FLIGHT_N*ADDR_W-1:0]  flightAddr;
  logic [$clog2(FLIGHT_N)-1:0] slotIdx;
  logic [31:0]                 rnd;
  logic [TAG_W-1:0]            t;
  logic [TAG_W-1:0]            tags [NUM_WAYS];
  logic [LINE_W-1:0]           lines [NUM_WAYS];
  int                          fails, checksDone, off, i;

  sac_cache i_sac_cache (.clk, .rst_b, .accValid, .accWrite, .accAddr, .accWdata, .accBe,
    .accHit, .accMiss, .accRdata, .accWay, .fetValid, .fetAddr, .fetHit, .fetData, .fetPred,
    .fillValid, .fillInstr, .fillAddr, .fillData, .fillPred, .fillExcl, .fillWayOut,
    .flightValid, .flightAddr, .serializeExec, .pipeFlush, .fetchRestart, .icInvalidate);
  sac_pipe_model i_sac_pipe_model (.clk, .rst_b, .pipeFlush, .slotLoad, .slotIdx, .slotAddr,
    .serReq, .flightValid, .flightAddr, .serializeExec);

  always #5 clk = ~clk;

  function automatic logic [31:0] nxt();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd;
  endfunction
  function automatic logic [LINE_W-1:0] rline();
    return {nxt(), nxt(), nxt(), nxt()};
  endfunction
  function automatic logic [ADDR_W-1:0] ad(input logic [TAG_W-1:0] tg, input int s, input int o);
    return {tg, IDX_W'(s), OFF_W'(o)};
  endfunction
  function automatic logic [63:0] rdExp(input logic [LINE_W-1:0] l, input int o);
    return 64'(l >> (o * 8));
  endfunction
  // bytes running past the line end are dropped, not wrapped
  function automatic logic [LINE_W-1:0] stExp(input logic [LINE_W-1:0] l, input int o,
                                              input logic [63:0] w, input logic [7:0] be);
    for (int b = 0; b < 8; b++) begin
      if (be[b] && o + b < LINE_BYTES) begin
        l[(o + b) * 8 +: 8] = w[b * 8 +: 8];
      end
    end
    return l;
  endfunction

  task automatic chkFlag(input string what, input logic exp, input logic got);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chkVal(input string what, input logic [127:0] exp, input logic [127:0] got);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stopTest();
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [63:0] wd,
                     input logic [7:0] be);
    @(posedge clk);
    accValid <= 1'b1;
    accWrite <= w;
    accAddr  <= a;
    accWdata <= wd;
    accBe    <= be;
    @(posedge clk);
    accValid <= 1'b0;
    accWrite <= 1'b0;
    accAddr  <= ~a;
    accWdata <= ~wd;
    @(negedge clk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic h, input logic [WAY_W-1:0] w,
                    input logic [63:0] exp);
    acc(1'b0, a, 64'h0, 8'h00);
    chkFlag("accHit", h, accHit);
    chkFlag("accMiss", !h, accMiss);
    if (h) begin
      chkVal("accWay", w, accWay);
      chkVal("accRdata", exp, accRdata);
    end
  endtask
  task automatic fill(input logic ins, input logic [ADDR_W-1:0] a, input logic [LINE_W-1:0] l,
                      input logic [WAY_W-1:0] w);
    @(posedge clk);
    fillValid <= 1'b1;
    fillInstr <= ins;
    fillAddr  <= a;
    fillData  <= l;
    fillPred  <= l[7:0] ^ 8'hA5;
    fillExcl  <= l[8];
    @(posedge clk);
    fillValid <= 1'b0;
    fillData  <= ~l;
    @(negedge clk);
    chkVal("fillWayOut", w, fillWayOut);
  endtask
  task automatic fet(input logic [ADDR_W-1:0] a, input logic h, input logic [LINE_W-1:0] l);
    @(posedge clk);
    fetValid <= 1'b1;
    fetAddr  <= a;
    @(posedge clk);
    fetValid <= 1'b0;
    @(negedge clk);
    chkFlag("fetHit", h, fetHit);
    if (h) begin
      chkVal("fetData", rdExp(l, int'(a[OFF_W-1:0])), fetData);
      chkVal("fetPred", l[7:0] ^ 8'hA5, fetPred);
    end
  endtask

  initial begin
    {clk, rst_b, accValid, accWrite, fetValid, fillValid, fillInstr, fillExcl, slotLoad} = '0;
    {accAddr, fetAddr, fillAddr, slotAddr, accWdata, accBe, fillPred, fillData} = '0;
    {serReq, slotIdx} = '0;
    rnd = 32'hC627;
    fails = 0;
    checksDone = 0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    chkFlag("accHit", 1'b0, accHit);
    chkFlag("pipeFlush", 1'b0, pipeFlush);
    chkFlag("icInvalidate", 1'b0, icInvalidate);
    rd(ad(TAG_W'(nxt()), 3, 0), 1'b0, 2'h0, 64'h0);
    for (int k = 0; k < NUM_WAYS; k++) begin
      tags[k]  = {(TAG_W-2)'(nxt()), 2'(k)};
      lines[k] = rline();
      fill(1'b0, ad(tags[k], 3, 0), lines[k], WAY_W'(k));
    end
    for (int k = 0; k < NUM_WAYS; k++) begin
      off = nxt() % LINE_BYTES;
      rd(ad(tags[k], 3, off), 1'b1, WAY_W'(k), rdExp(lines[k], off));
    end
    // set full: least recently touched way is the one evicted
    t        = tags[0];
    tags[0]  = ~t;
    lines[0] = rline();
    fill(1'b0, ad(tags[0], 3, 0), lines[0], 2'h0);
    rd(ad(t, 3, 0), 1'b0, 2'h0, 64'h0);
    rd(ad(tags[0], 3, 15), 1'b1, 2'h0, rdExp(lines[0], 15));
    d = {nxt(), nxt()};
    acc(1'b1, ad(tags[1], 3, 12), d, 8'hFF);
    chkFlag("accHit", 1'b1, accHit);
    chkFlag("pipeFlush", 1'b0, pipeFlush);
    lines[1] = stExp(lines[1], 12, d, 8'hFF);
    rd(ad(tags[1], 3, 8), 1'b1, 2'h1, rdExp(lines[1], 8));
    t  = TAG_W'(nxt());
    ln = rline();
    fill(1'b1, ad(t, 5, 0), ln, 2'h0);
    fet(ad(t, 5, 4), 1'b1, ln);
    @(posedge clk);
    slotLoad <= 1'b1;
    slotAddr <= ad(t, 5, 8);
    @(posedge clk);
    slotLoad <= 1'b0;
    acc(1'b1, ad(t, 5, 0), d, 8'h0F);
    chkFlag("icInvalidate", 1'b1, icInvalidate);
    chkFlag("pipeFlush", 1'b0, pipeFlush);
    fet(ad(t, 5, 4), 1'b0, ln);
    fill(1'b1, ad(t, 5, 0), ln, 2'h0);
    acc(1'b1, ad(t, 5, 12), d, 8'h0F);
    chkFlag("pipeFlush", 1'b1, pipeFlush);
    chkFlag("icInvalidate", 1'b1, icInvalidate);
    @(negedge clk);
    chkFlag("fetchRestart", 1'b1, fetchRestart);
    chkFlag("pipeFlush", 1'b0, pipeFlush);
    fill(1'b1, ad(t, 6, 0), ln, 2'h0);
    @(posedge clk);
    serReq <= 1'b1;
    @(posedge clk);
    serReq <= 1'b0;
    i = 0;
    while (pipeFlush !== 1'b1 && i < 8) begin
      @(negedge clk);
      i++;
    end
    if (i == 8) begin
      fails++;
      stopTest();
    end
    chkFlag("pipeFlush", 1'b1, pipeFlush);
    fet(ad(t, 6, 0), 1'b0, ln);
    for (int s = 8; s < NUM_SETS; s++) begin
      t   = TAG_W'(nxt());
      ln  = rline();
      off = nxt() % LINE_BYTES;
      fill(1'b0, ad(t, s, 0), ln, 2'h0);
      rd(ad(t, s, off), 1'b1, 2'h0, rdExp(ln, off));
    end
    stopTest();
  end
endmodule
`default_nettype wire
